// [rtl/vts_consts.vh]
// Constants for the vector table select and map block
// Behaviour
// RQ1 - Select bit set makes every trap and interrupt fetch from the alternate table
// RQ2 - Alternate table keeps the same entry order and spacing as the default table
// RQ3 - Alternate base is boot page start; traps +04h, sources +14h, code +100h
// RQ4 - Without a boot segment fetches always use the default table
// RQ5 - Reset clears registers and points the fetch address at 000000h
// RQ6 - Software places a jump and its target at the reset location
// RQ7 - Software fills unused entries with a default handler that resets
// RQ8 - Unused alternate table should hold the same addresses as the default
// RQ9 - Eight trap entries sit at consecutive words from 000004h to 000012h
// RQ10 - Priority falls with table position; traps 15 down to 11
// RQ11 - Source zero at 000014h, each next source two addresses on, 116 at 0000FCh
// RQ12 - Sources 52, 53, 54 fetch from 00007Ch, 00007Eh, 000080h
// RQ13 - Toggling the select bit switches environments without rewriting entries
// RQ14 - Each source has flag, enable and three-bit priority, four fields per register
// RQ15 - Taking oscillator or address trap sets generic flag bit 1 or 3
// RQ16 - Each entry yields a 24-bit handler address for the program counter
// RQ17 - Default table holds 8 trap entries and up to 118 source entries
`ifndef VTS_CONSTS_VH
`define VTS_CONSTS_VH

// Register byte offsets
`define VTS_OFF_CTRL_ONE    12'h000
`define VTS_OFF_CTRL_TWO    12'h004
`define VTS_OFF_BOOT_BASE   12'h008
`define VTS_OFF_EVT_STATUS  12'h00C
`define VTS_OFF_EVT_MASK    12'h010
`define VTS_OFF_LAST_VEC    12'h014
`define VTS_OFF_FLAG_BASE   12'h100
`define VTS_OFF_ENABLE_BASE 12'h140
`define VTS_OFF_PRIO_BASE   12'h180
`define VTS_FLAG_REGS       8
`define VTS_PRIO_REGS       30

// Table shape
`define VTS_NUM_SOURCES     118
`define VTS_NUM_TRAPS       8
`define VTS_TRAP_RSVD_A     5
`define VTS_TRAP_RSVD_B     7

// Field positions
`define VTS_ALT_SEL_BIT     8
`define VTS_GEN_OSC_BIT     1
`define VTS_GEN_ADDR_BIT    3
`define VTS_EVT_SRC_TAKEN   0
`define VTS_EVT_TRAP_TAKEN  1
`define VTS_EVT_BAD_ACCESS  2
`define VTS_EVT_BITS        3

// Entry offsets from a table base
`define VTS_TRAP_OFFSET     24'h000004
`define VTS_SOURCE_OFFSET   24'h000014
`define VTS_CODE_OFFSET     24'h000100
`define VTS_RESET_ADDR      24'h000000

// Fixed trap priorities
`define VTS_TRAP_TOP_PRIO   4'hF
`define VTS_SOFT_TRAP_PRIO  4'h8

`endif

// [rtl/vts_addr.v]
// Vector number to handler-fetch address mapping
`timescale 1ns/1ps
`default_nettype none
`include "vts_consts.vh"

module vts_addr (
    // Table choice
    input  wire        alt_select,
    input  wire        boot_present,
    input  wire [23:0] boot_base,
    // Vector in, address out
    input  wire [6:0]  vec_num,
    output wire [23:0] fetch_addr,
    output wire [23:0] code_start
);
    wire [23:0] base;
    wire [23:0] step;

    // Alternate table only exists with a boot segment
    assign base = (alt_select && boot_present) ? boot_base : 24'h000000; // RQ1 RQ4 RQ13

    // Word step of two; traps below vector 8, sources above
    assign step = (vec_num < 7'h08)
                ? (`VTS_TRAP_OFFSET + {16'h0000, vec_num, 1'b0}) // RQ9
                : (`VTS_SOURCE_OFFSET + {16'h0000, vec_num - 7'h08, 1'b0}); // RQ11 RQ12

    // Same offsets in either table
    assign fetch_addr = base + step; // RQ2 RQ3 RQ16
    assign code_start = base + `VTS_CODE_OFFSET; // RQ3
endmodule

`default_nettype wire

// [rtl/vts_top.v]
// Vector table select, source flags and vector request toward the core
`timescale 1ns/1ps
`default_nettype none
`include "vts_consts.vh"

module vts_top (
    // Clock and reset
    input  wire         clock,
    input  wire         resetn,
    // APB slave
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [11:0]  paddr,
    input  wire [31:0]  pwdata,
    output wire         pready,
    output reg  [31:0]  prdata,
    output reg          pslverr,
    // Request lines
    input  wire [117:0] src_req,
    input  wire [7:0]   trap_req,
    // Boot segment straps
    input  wire         boot_present,
    input  wire [23:0]  boot_base,
    // Core side
    input  wire [3:0]   cpu_ipl,
    input  wire         cpu_ack,
    output reg          vec_req,
    output reg  [6:0]   vec_num,
    output reg  [3:0]   vec_prio,
    output reg  [23:0]  vec_addr,
    output reg  [23:0]  app_code_start,
    // Event interrupt
    output wire         irq
);
    integer i;
    integer j;

    // In-window test, used for every register group
    function in_win;
        input [11:0] a;
        input [11:0] base;
        input [6:0]  n;
        begin
            in_win = (a >= base) && (a < base + {3'b000, n, 2'b00});
        end
    endfunction

    // Word index inside a group
    function [5:0] word_of;
        input [11:0] a;
        input [11:0] base;
        reg   [11:0] d;
        begin
            d = a - base;
            word_of = d[7:2];
        end
    endfunction

    reg          alt_sel;
    reg          gen_osc;
    reg          gen_addr;
    reg  [2:0]   evt_status;
    reg  [2:0]   evt_mask;
    reg  [23:0]  last_vec;
    reg  [7:0]   trap_pend;
    wire [2:0]   prio [0:119];
    wire [127:0] flag;
    wire [127:0] enab;

    wire setup_ph = psel & ~penable;
    wire wr_acc   = psel & penable & pwrite & (paddr[1:0] == 2'b00); // Unaligned writes refused
    wire take     = cpu_ack & vec_req;
    wire is_trap  = (vec_num < 7'h08);

    // Zero wait states; data and error prepared at setup
    assign pready = 1'b1;

    // Per-source flag and enable bits; set beats software and ack clears
    genvar g;
    generate
        for (g = 0; g < 128; g = g + 1) begin : g_src
            if (g < `VTS_NUM_SOURCES) begin : g_real
                reg f;
                reg e;
                wire fw = wr_acc && in_win(paddr, `VTS_OFF_FLAG_BASE, 7'd8)
                          && (word_of(paddr, `VTS_OFF_FLAG_BASE) == g / 16);
                wire ew = wr_acc && in_win(paddr, `VTS_OFF_ENABLE_BASE, 7'd8)
                          && (word_of(paddr, `VTS_OFF_ENABLE_BASE) == g / 16);
                wire clr = take && !is_trap && (vec_num == g + 8);
                always @(posedge clock or negedge resetn) begin
                    if (!resetn) begin
                        f <= 1'b0; // RQ5
                        e <= 1'b0;
                    end else begin
                        if (src_req[g])
                            f <= 1'b1; // RQ14
                        else if (clr)
                            f <= 1'b0;
                        else if (fw)
                            f <= pwdata[g % 16];
                        if (ew)
                            e <= pwdata[g % 16]; // RQ14
                    end
                end
                assign flag[g] = f;
                assign enab[g] = e;
            end else begin : g_pad
                assign flag[g] = 1'b0;
                assign enab[g] = 1'b0;
            end
        end
        // Priority fields, four to a register at 2:0, 6:4, 10:8, 14:12
        for (g = 0; g < 120; g = g + 1) begin : g_prio
            reg  [2:0] p;
            wire pw = wr_acc && in_win(paddr, `VTS_OFF_PRIO_BASE, 7'd30)
                      && (word_of(paddr, `VTS_OFF_PRIO_BASE) == g / 4);
            // One register per field keeps a single driver per element
            always @(posedge clock or negedge resetn) begin
                if (!resetn)
                    p <= 3'b000;
                else if (pw)
                    p <= pwdata[(g % 4) * 4 +: 3]; // RQ14
            end
            assign prio[g] = p;
        end
    endgenerate

    // Winner search: traps first, then highest source priority, lowest index on a tie
    reg       found;
    reg       src_found;
    reg [6:0] best_trap;
    reg [6:0] best_src;
    reg [2:0] best_p;
    reg [6:0] next_num;
    reg [3:0] next_prio;
    always @* begin
        found     = 1'b0;
        src_found = 1'b0;
        best_trap = 7'h00;
        best_src  = 7'h00;
        best_p    = 3'b000;
        for (i = `VTS_NUM_TRAPS - 1; i >= 0; i = i - 1) begin
            if (trap_pend[i] && i != `VTS_TRAP_RSVD_A && i != `VTS_TRAP_RSVD_B) begin
                found     = 1'b1;
                best_trap = i[6:0]; // RQ10
            end
        end
        for (i = `VTS_NUM_SOURCES - 1; i >= 0; i = i - 1) begin
            if (flag[i] && enab[i] && prio[i] != 3'b000 && prio[i] >= best_p) begin
                src_found = 1'b1;
                best_p    = prio[i];
                best_src  = i[6:0]; // RQ10
            end
        end
        if (found) begin
            next_num = best_trap;
            if (best_trap < 7'h05)
                next_prio = `VTS_TRAP_TOP_PRIO - best_trap[3:0]; // RQ10
            else
                next_prio = `VTS_SOFT_TRAP_PRIO;
        end else begin
            // Sources only reach the core above its current level
            found     = src_found && ({1'b0, best_p} > cpu_ipl);
            next_num  = best_src + 7'h08; // RQ17
            next_prio = {1'b0, best_p};
        end
    end

    wire [23:0] next_addr;
    wire [23:0] next_code;

    // Address mapping for the chosen vector
    vts_addr u_addr (
        .alt_select   (alt_sel),
        .boot_present (boot_present),
        .boot_base    (boot_base),
        .vec_num      (next_num),
        .fetch_addr   (next_addr),
        .code_start   (next_code)
    );

    // Vector request toward the core; one idle cycle after each ack
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            vec_req        <= 1'b0;
            vec_num        <= 7'h00;
            vec_prio       <= 4'h0;
            vec_addr       <= `VTS_RESET_ADDR; // RQ5
            app_code_start <= `VTS_CODE_OFFSET;
            last_vec       <= `VTS_RESET_ADDR;
        end else begin
            // Drop the request at the ack so a stale winner is not offered twice
            vec_req        <= found && !take;
            app_code_start <= next_code; // RQ3
            if (take)
                last_vec <= vec_addr; // RQ16
            if (!take && found) begin
                vec_num  <= next_num;
                vec_prio <= next_prio;
                vec_addr <= next_addr; // RQ1 RQ16
            end
        end
    end

    // Trap latches and generic flags; hardware set beats software write
    wire wr_one = wr_acc && paddr == `VTS_OFF_CTRL_ONE;
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            trap_pend <= 8'h00;
            gen_osc   <= 1'b0;
            gen_addr  <= 1'b0;
        end else begin
            for (j = 0; j < `VTS_NUM_TRAPS; j = j + 1) begin
                if (trap_req[j])
                    trap_pend[j] <= 1'b1;
                else if (take && is_trap && vec_num == j)
                    trap_pend[j] <= 1'b0;
            end
            if (take && vec_num == 7'h00)
                gen_osc <= 1'b1; // RQ15
            else if (wr_one)
                gen_osc <= pwdata[`VTS_GEN_OSC_BIT];
            if (take && vec_num == 7'h01)
                gen_addr <= 1'b1; // RQ15
            else if (wr_one)
                gen_addr <= pwdata[`VTS_GEN_ADDR_BIT];
        end
    end

    // Table select bit
    always @(posedge clock or negedge resetn) begin
        if (!resetn)
            alt_sel <= 1'b0; // RQ5
        else if (wr_acc && paddr == `VTS_OFF_CTRL_TWO)
            alt_sel <= pwdata[`VTS_ALT_SEL_BIT]; // RQ1 RQ13
    end

    // Address decode for reads and errors
    reg        hit;
    reg [15:0] rd;
    reg [5:0]  w;
    always @* begin
        hit = 1'b1;
        rd  = 16'h0000;
        w   = 6'h00;
        if (paddr[1:0] != 2'b00) begin
            hit = 1'b0;
        end else if (paddr == `VTS_OFF_CTRL_ONE) begin
            rd[`VTS_GEN_OSC_BIT]  = gen_osc;
            rd[`VTS_GEN_ADDR_BIT] = gen_addr;
        end else if (paddr == `VTS_OFF_CTRL_TWO) begin
            rd[`VTS_ALT_SEL_BIT] = alt_sel;
        end else if (paddr == `VTS_OFF_BOOT_BASE) begin
            rd = boot_base[15:0];
        end else if (paddr == `VTS_OFF_EVT_STATUS) begin
            rd = {13'h0000, evt_status};
        end else if (paddr == `VTS_OFF_EVT_MASK) begin
            rd = {13'h0000, evt_mask};
        end else if (paddr == `VTS_OFF_LAST_VEC) begin
            rd = last_vec[15:0];
        end else if (in_win(paddr, `VTS_OFF_FLAG_BASE, 7'd8)) begin
            w  = word_of(paddr, `VTS_OFF_FLAG_BASE);
            rd = flag[w[2:0] * 16 +: 16];
        end else if (in_win(paddr, `VTS_OFF_ENABLE_BASE, 7'd8)) begin
            w  = word_of(paddr, `VTS_OFF_ENABLE_BASE);
            rd = enab[w[2:0] * 16 +: 16];
        end else if (in_win(paddr, `VTS_OFF_PRIO_BASE, 7'd30)) begin
            w  = word_of(paddr, `VTS_OFF_PRIO_BASE);
            rd = {1'b0, prio[w * 4 + 3], 1'b0, prio[w * 4 + 2],
                  1'b0, prio[w * 4 + 1], 1'b0, prio[w * 4]};
        end else begin
            hit = 1'b0;
        end
    end

    // Upper byte of 24-bit registers sits in the high half
    reg [31:0] next_rdata;
    always @* begin
        next_rdata = {16'h0000, rd};
        if (paddr == `VTS_OFF_BOOT_BASE)
            next_rdata[23:16] = boot_base[23:16];
        if (paddr == `VTS_OFF_LAST_VEC)
            next_rdata[23:16] = last_vec[23:16];
    end

    // Read data and error captured in setup, shown in the access phase
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata  <= (hit && !pwrite) ? next_rdata : 32'h00000000;
            pslverr <= !hit;
        end
    end

    // Event status, write one to clear; a new event wins
    wire [2:0] evt_in = {psel & penable & pslverr, take & is_trap, take & !is_trap};
    wire       wr_st  = wr_acc && paddr == `VTS_OFF_EVT_STATUS;
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            evt_status <= 3'b000;
            evt_mask   <= 3'b000;
        end else begin
            evt_status <= (evt_status & ~(wr_st ? pwdata[2:0] : 3'b000)) | evt_in;
            if (wr_acc && paddr == `VTS_OFF_EVT_MASK)
                evt_mask <= pwdata[2:0];
        end
    end

    // Level interrupt while any unmasked event is pending
    assign irq = |(evt_status & evt_mask);
endmodule

`default_nettype wire

// [testbench/vts_top_chk.sv]
// Port-level assertions for the vector select and map block
`timescale 1ns/1ps
`default_nettype none
module vts_top_chk (
    // Clock, reset and straps
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        boot_present,
    input wire logic [23:0] boot_base,
    input wire logic [7:0]  trap_req,
    // Core side
    input wire logic        vec_req,
    input wire logic [6:0]  vec_num,
    input wire logic [3:0]  vec_prio,
    input wire logic [23:0] vec_addr,
    input wire logic [23:0] app_code_start
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // Offer state straight after reset release
    AST_RESET_STATE: assert property (
        $rose(resetn) |-> !vec_req && vec_addr == 24'h000000 && app_code_start == 24'h000100)
        else $error("fetch state not cleared by reset");
    // Either table keeps the two-address step from entry 04h
    AST_ADDR_MAP: assert property (
        vec_req |-> vec_addr == 24'h000004 + {vec_num, 1'b0}
        || boot_present && vec_addr == boot_base + 24'h000004 + {vec_num, 1'b0})
        else $error("vector address off the table");
    // No boot segment means the default table only
    AST_NO_BOOT: assert property (
        vec_req && !boot_present && !$past(boot_present, 3)
        |-> vec_addr == 24'h000004 + {vec_num, 1'b0})
        else $error("alternate table used without boot segment");
    // Code start sits 100h above the selected base
    AST_CODE_START: assert property (
        $stable(boot_present) |-> app_code_start == 24'h000100
        || boot_present && app_code_start == boot_base + 24'h000100)
        else $error("code start not base plus 100h");
    // Fixed trap priorities 15 down to 11
    AST_TRAP_PRIO: assert property (
        vec_req && vec_num < 7'd5 |-> vec_prio == 4'hF - vec_num[3:0])
        else $error("trap priority wrong");
    // Top trap offered within two edges of its request when no offer is up
    AST_TRAP_FIRST: assert property (
        $rose(trap_req[0]) && !vec_req |-> ##2 vec_req && vec_num == 7'h00)
        else $error("oscillator trap not offered in two cycles");
    // Reserved traps never offered
    AST_RESV_TRAP: assert property (
        vec_req |-> vec_num != 7'd5 && vec_num != 7'd7 && vec_num <= 7'd125)
        else $error("reserved or absent vector offered");
    // Sources carry a user priority 1..7
    AST_SRC_PRIO: assert property (
        vec_req && vec_num >= 7'd8 |-> vec_prio inside {[4'h1:4'h7]})
        else $error("source priority out of range");
endmodule

bind vts_top vts_top_chk i_chk (.clock(clock), .resetn(resetn), .boot_present(boot_present),
    .boot_base(boot_base), .trap_req(trap_req), .vec_req(vec_req), .vec_num(vec_num),
    .vec_prio(vec_prio), .vec_addr(vec_addr), .app_code_start(app_code_start));
`default_nettype wire

// [testbench/vts_core_model.sv]
// Behavioural core that takes offered vectors and loads their addresses
`timescale 1ns/1ps
`default_nettype none
module vts_core_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // Offer and ack pacing
    input  wire logic        vec_req,
    input  wire logic [6:0]  vec_num,
    input  wire logic [23:0] vec_addr,
    input  wire logic [3:0]  ack_delay,
    // Ack and what was taken
    output var  logic        cpu_ack,
    output var  logic [23:0] pc,
    output var  logic [6:0]  taken_num,
    output var  logic        taken_stb
);
    logic [3:0] wait_cnt;

    // Offer may improve while ack is up, so the ack edge decides what is taken
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cpu_ack   <= 1'b0;
            pc        <= 24'h000000;
            taken_num <= 7'h00;
            taken_stb <= 1'b0;
            wait_cnt  <= 4'h0;
        end else begin
            taken_stb <= 1'b0;
            if (cpu_ack) begin
                cpu_ack   <= 1'b0;
                pc        <= vec_addr;
                taken_num <= vec_num;
                taken_stb <= 1'b1;
                wait_cnt  <= 4'h0;
            end else if (vec_req && wait_cnt >= ack_delay) begin
                cpu_ack <= 1'b1;
            end else if (vec_req) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/vector_table_select_and_map_test.sv]
// Self-checking bench for the vector select and map block
`timescale 1ns/1ps
`default_nettype none
module vector_table_select_and_map_test;
    logic         clock, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic         boot_present, cpu_ack, vec_req, irq, taken_stb;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd, pw;
    logic [117:0] src_req;
    logic [7:0]   trap_req;
    logic [23:0]  boot_base, vec_addr, app_code_start, pc;
    logic [6:0]   vec_num, taken_num;
    logic [3:0]   cpu_ipl, vec_prio, ack_delay;
    logic [2:0]   prio_of [0:119];
    integer       seed = 24334, n_mismatch = 0, cmp_count = 0, i, k, m, a, b;
    int           traps [6] = '{0, 1, 2, 3, 4, 6};
    int           srcs [8] = '{0, 1, 52, 53, 54, 116, 117, 9};

    vts_top i_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .src_req(src_req), .trap_req(trap_req), .boot_present(boot_present),
        .boot_base(boot_base), .cpu_ipl(cpu_ipl), .cpu_ack(cpu_ack), .vec_req(vec_req),
        .vec_num(vec_num), .vec_prio(vec_prio), .vec_addr(vec_addr),
        .app_code_start(app_code_start), .irq(irq));
    vts_core_model i_core (.clock(clock), .resetn(resetn), .vec_req(vec_req),
        .vec_num(vec_num), .vec_addr(vec_addr), .ack_delay(ack_delay), .cpu_ack(cpu_ack),
        .pc(pc), .taken_num(taken_num), .taken_stb(taken_stb));

    // Expected table base and service order
    function automatic logic [23:0] exp_base(input logic alt);
        return (alt && boot_present) ? boot_base : 24'h000000;
    endfunction
    function automatic integer first_of(input integer x, input integer y);
        return (prio_of[x] > prio_of[y] || (prio_of[x] == prio_of[y] && x < y)) ? x : y;
    endfunction

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic fail(input string msg);
        n_mismatch++;
        $display("mismatch at %0t: %s", $time, msg);
        tally_and_finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] d);
        integer t;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (t = 0; t < 1 || pready !== 1'b1; t++) begin
            if (t > 20) fail("bus hang");
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One-cycle request pulse: sources above bit 7, traps below
    task automatic pulse(input logic [125:0] v);
        @(posedge clock);
        trap_req <= v[7:0];
        src_req <= v[125:8];
        @(posedge clock);
        trap_req <= 8'h00;
        src_req <= '0;
    endtask

    // Wait for the core to take a vector, then compare it
    task automatic take(input logic [6:0] num, input logic [23:0] base);
        integer t;
        for (t = 0; taken_stb !== 1'b1; t++) begin
            if (t > 60) fail("no vector taken");
            @(negedge clock);
        end
        check(taken_num, num, "vector number");
        check(pc, base + 24'h000004 + {num, 1'b0}, "handler address");
        @(negedge clock);
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata, src_req, trap_req} = '0;
        {cpu_ipl, ack_delay} = '0;
        boot_present = 1'b1;
        boot_base = $random(seed) & 24'hFFFF00;
        repeat (2) @(posedge clock);
        check(vec_addr, 0, "reset address");
        check(app_code_start, 24'h100, "reset code start");
        resetn <= 1'b1;
        apb(0, 12'h004, 0);
        check(rd, 0, "control two");
        // Enable all sources, random non-zero priorities
        for (i = 0; i < 8; i++) apb(1, 12'h140 + 4 * i, 32'hFFFF);
        for (i = 0; i < 30; i++) begin
            pw = 0;
            for (k = 0; k < 4; k++) begin
                prio_of[4 * i + k] = {$random(seed)} % 7 + 1;
                pw = pw | (prio_of[4 * i + k] << (4 * k));
            end
            apb(1, 12'h180 + 4 * i, pw);
            apb(0, 12'h180 + 4 * i, 0);
            check(rd, pw, "priority fields");
        end
        // Every table choice against the same entries, no rewrites between
        for (m = 0; m < 4; m++) begin
            boot_present <= m[1];
            apb(1, 12'h004, {23'h0, m[0], 8'h00});
            ack_delay <= {$random(seed)} % 4;
            srcs[7] = {$random(seed)} % 118;
            repeat (3) @(posedge clock);
            check(app_code_start, exp_base(m[0]) + 24'h100, "code start");
            foreach (traps[j]) begin
                pulse(126'h1 << traps[j]);
                take(traps[j], exp_base(m[0]));
            end
            foreach (srcs[j]) begin
                pulse(126'h1 << (srcs[j] + 8));
                take(srcs[j] + 8, exp_base(m[0]));
            end
        end
        apb(0, 12'h000, 0);
        check(rd & 32'hA, 32'hA, "generic trap flags");
        // Traps before sources, sources by priority then index
        for (i = 0; i < 6; i++) begin
            a = {$random(seed)} % 118;
            b = (a + 1 + {$random(seed)} % 117) % 118;
            pulse(126'h1 << (a + 8) | 126'h1 << (b + 8) | 126'hAA);
            take(1, exp_base(1));
            take(3, exp_base(1));
            take(first_of(a, b) + 8, exp_base(1));
            take((first_of(a, b) == a ? b : a) + 8, exp_base(1));
        end
        // Core level at the top holds every source back
        cpu_ipl <= 4'h7;
        pulse(126'h1 << 9);
        repeat (4) @(posedge clock);
        check(vec_req, 0, "offer above core level");
        cpu_ipl <= 4'h0;
        take(9, exp_base(1));
        // Events: masked, raised by a bad access, cleared by writing ones
        check(irq, 0, "masked events");
        apb(1, 12'h010, 4);
        apb(0, 12'h020, 0);
        check(rd, 0, "unmapped read data");
        check(err, 1, "unmapped error");
        @(negedge clock);
        check(irq, 1, "bad access interrupt");
        apb(1, 12'h00C, 7);
        apb(0, 12'h00C, 0);
        check(rd, 0, "status cleared");
        check(irq, 0, "interrupt cleared");
        // Reset in mid-run with the alternate table selected
        @(posedge clock);
        resetn <= 1'b0;
        @(negedge clock);
        check(vec_addr, 0, "second reset address");
        @(posedge clock);
        resetn <= 1'b1;
        apb(0, 12'h004, 0);
        check(rd, 0, "select cleared by reset");
        tally_and_finish;
    end
endmodule
`default_nettype wire
